/* shared/tsa_pkg.sv */
// constants, types and register map of the triggered spectrum acquisition block
`default_nettype none
package tsa_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXPO = 8'h04;
  localparam logic [7:0] ADDR_FRAMES = 8'h08;
  localparam logic [7:0] ADDR_OFFSET = 8'h0C;
  localparam logic [7:0] ADDR_UIO = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_LIST = 8'h20;
  localparam int unsigned LIST_DEPTH = 8;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_EDGE_BIT = 2;
  localparam int unsigned CTRL_ARM_BIT = 3;
  localparam int unsigned CTRL_LIGHT_BIT = 4;
  localparam int unsigned UIO_OE_LSB = 8;
  localparam int unsigned UIO_IN_LSB = 16;
  localparam int unsigned STAT_STORED_LSB = 16;
  localparam int unsigned UIO_WIDTH = 6;
  localparam logic [11:0] PIX_DUMMY_A_LAST = 12'h00C;
  localparam logic [11:0] PIX_BLACK_LAST = 12'h01E;
  localparam logic [11:0] PIX_DUMMY_B_LAST = 12'h020;
  localparam logic [11:0] PIX_ACTIVE_LAST = 12'h820;
  localparam logic [11:0] PIX_LINE_LAST = 12'h826;
  localparam int unsigned WARM_PULSES = 22500;
  localparam logic [11:0] MAX_SPECTRA = 12'hFA0;
  localparam logic [15:0] PIX_FULL_SCALE = 16'hFFFF;
  localparam logic [15:0] OFFSET_RST = 16'h03E8;
  localparam logic [31:0] EXPO_RST = 32'h0000_C350;
  localparam logic [11:0] FRAMES_RST = 12'h001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_SINGLE = 2'h0, MODE_FRAMES = 2'h1, MODE_LIST = 2'h2} tsa_mode_t;
  typedef enum logic [1:0] {REG_DUMMY = 2'h0, REG_BLACK = 2'h1, REG_ACTIVE = 2'h2} tsa_region_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_WAIT = 3'h1, ST_EXPOSE = 3'h3, ST_DRAIN = 3'h2, ST_DONE = 3'h6
  } tsa_state_t;
  typedef struct packed {
    tsa_region_t region;
    logic [15:0] value;
  } tsa_pix_t;
endpackage
`default_nettype wire

/* core/tsa_fifo.sv */
// pixel FIFO with a registered read stage
`timescale 1ns/1ps
`default_nettype none
module tsa_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic [WIDTH-1:0] dout_ff, nxt_dout;
  logic ovalid_ff, nxt_ovalid;
  logic push, pop;

  assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
  assign out_data_o = dout_ff;
  assign out_valid_o = ovalid_ff;

  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop = (cnt_ff != '0) && (!ovalid_ff || out_ready_i);
    nxt_wr = push ? wr_ff + AW'(1) : wr_ff;
    nxt_rd = pop ? rd_ff + AW'(1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    nxt_dout = pop ? mem[rd_ff] : dout_ff;
    nxt_ovalid = pop ? 1'b1 : (out_ready_i ? 1'b0 : ovalid_ff);
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && push)
    begin
      mem[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      dout_ff <= '0;
      ovalid_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      dout_ff <= nxt_dout;
      ovalid_ff <= nxt_ovalid;
    end
  end
endmodule // tsa_fifo
`default_nettype wire

/* core/tsa_top.sv */
// acquisition controller: register slave, trigger modes, sensor readout, pixel stream
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module tsa_top #(
  parameter int unsigned SCLK_DIV = 2,
  parameter int unsigned WARM_PULSES = tsa_pkg::WARM_PULSES,
  parameter int unsigned FIFO_DEPTH = 32
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic TRIGGER_I,
  input wire logic [15:0] PIX_DATA_I,
  input wire logic [5:0] USER_IO_I,
  output logic [5:0] USER_IO_O,
  output logic [5:0] USER_IO_OE_O,
  output logic LIGHT_SOURCE_O,
  output logic [15:0] FE_OFFSET_O,
  output logic SENSOR_CLK_O,
  output logic SENSOR_XFER_O,
  output tsa_pkg::tsa_pix_t SPEC_TDATA_O,
  output logic SPEC_TVALID_O,
  input wire logic SPEC_TREADY_I,
  output logic HOST_SEND_O,
  output logic ACQ_BUSY_O
);
  import tsa_pkg::*;

  localparam logic [7:0] DIV_LAST = 8'(SCLK_DIV - 1);
  localparam logic [14:0] WARM_LAST = 15'(WARM_PULSES - 1);

  // pin synchronisers
  logic trig_s1_ff, trig_s2_ff, trig_s3_ff;
  logic [15:0] pix_s1_ff, pix_s2_ff;
  logic [5:0] uio_s1_ff, uio_s2_ff;

  // software state
  tsa_mode_t mode_ff, nxt_mode;
  logic edge_ff, nxt_edge, light_ff, nxt_light;
  logic [31:0] expo_ff, nxt_expo;
  logic [11:0] frames_ff, nxt_frames;
  logic [15:0] offset_ff, nxt_offset;
  logic [5:0] uout_ff, nxt_uout, uoe_ff, nxt_uoe;
  logic [31:0] list_ff [LIST_DEPTH];
  logic [31:0] nxt_list [LIST_DEPTH];

  // bus handshake
  logic awready_ff, nxt_awready, bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_fire, rd_fire, wr_hit, arm;

  // acquisition
  tsa_state_t state_ff, nxt_state;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [11:0] taken_ff, nxt_taken, stored_ff, nxt_stored, pix_ff, nxt_pix;
  logic [2:0] idx_ff, nxt_idx;
  logic xfer_ff, nxt_xfer, send_ff, nxt_send, rd_busy_ff, nxt_rd_busy, busy_ff, nxt_busy;
  logic [7:0] div_ff, nxt_div;
  logic sclk_ff, nxt_sclk, warm_ok_ff, nxt_warm_ok;
  logic [14:0] warm_ff, nxt_warm;
  logic trig_hit, arm_ok, fifo_ready, rise, stall, push, more;
  tsa_pix_t push_data;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic tsa_region_t classify(input logic [11:0] idx);
    tsa_region_t r;
    r = REG_DUMMY;
    if (idx > PIX_DUMMY_A_LAST && idx <= PIX_BLACK_LAST)
    begin
      r = REG_BLACK;
    end
    else if (idx > PIX_DUMMY_B_LAST && idx <= PIX_ACTIVE_LAST)
    begin
      r = REG_ACTIVE;
    end
    return r;
  endfunction

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      trig_s1_ff <= 1'b0;
      trig_s2_ff <= 1'b0;
      trig_s3_ff <= 1'b0;
      pix_s1_ff <= '0;
      pix_s2_ff <= '0;
      uio_s1_ff <= '0;
      uio_s2_ff <= '0;
    end
    else if (CE_I)
    begin
      trig_s1_ff <= TRIGGER_I;
      trig_s2_ff <= trig_s1_ff;
      trig_s3_ff <= trig_s2_ff;
      pix_s1_ff <= PIX_DATA_I;
      pix_s2_ff <= pix_s1_ff;
      uio_s1_ff <= USER_IO_I;
      uio_s2_ff <= uio_s1_ff;
    end
  end

  // write and read take place on the cycle the registered ready meets valid
  assign wr_fire = awready_ff && S_AXI_AWVALID_I && S_AXI_WVALID_I;
  assign rd_fire = arready_ff && S_AXI_ARVALID_I;
  assign arm = wr_fire && S_AXI_AWADDR_I == ADDR_CTRL && S_AXI_WSTRB_I[0] && S_AXI_WDATA_I[CTRL_ARM_BIT];

  always_comb
  begin
    nxt_awready = !awready_ff && !bvalid_ff && S_AXI_AWVALID_I && S_AXI_WVALID_I;
    nxt_arready = !arready_ff && !rvalid_ff && S_AXI_ARVALID_I;
    nxt_bvalid = wr_fire ? 1'b1 : (S_AXI_BREADY_I ? 1'b0 : bvalid_ff);
    nxt_rvalid = rd_fire ? 1'b1 : (S_AXI_RREADY_I ? 1'b0 : rvalid_ff);
    nxt_bresp = bresp_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    wr_hit = 1'b1;
    nxt_mode = mode_ff;
    nxt_edge = edge_ff;
    nxt_light = light_ff;
    nxt_expo = expo_ff;
    nxt_frames = frames_ff;
    nxt_offset = offset_ff;
    nxt_uout = uout_ff;
    nxt_uoe = uoe_ff;
    nxt_list = list_ff;
    if (wr_fire)
    begin
      case (S_AXI_AWADDR_I)
        ADDR_CTRL:
        begin
          if (S_AXI_WSTRB_I[0])
          begin
            nxt_mode = tsa_mode_t'(S_AXI_WDATA_I[CTRL_MODE_LSB +: 2]);
            nxt_edge = S_AXI_WDATA_I[CTRL_EDGE_BIT];
            nxt_light = S_AXI_WDATA_I[CTRL_LIGHT_BIT];
          end
        end
        ADDR_EXPO: nxt_expo = merge(expo_ff, S_AXI_WDATA_I, S_AXI_WSTRB_I);
        ADDR_FRAMES: nxt_frames = 12'(merge({20'h0, frames_ff}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
        ADDR_OFFSET: nxt_offset = 16'(merge({16'h0, offset_ff}, S_AXI_WDATA_I, S_AXI_WSTRB_I));
        ADDR_UIO:
        begin
          if (S_AXI_WSTRB_I[0])
          begin
            nxt_uout = S_AXI_WDATA_I[5:0];
          end
          if (S_AXI_WSTRB_I[1])
          begin
            nxt_uoe = S_AXI_WDATA_I[UIO_OE_LSB +: UIO_WIDTH];
          end
        end
        default:
        begin
          if (S_AXI_AWADDR_I[7:5] == ADDR_LIST[7:5] && S_AXI_AWADDR_I[1:0] == 2'h0)
          begin
            nxt_list[S_AXI_AWADDR_I[4:2]] = merge(list_ff[S_AXI_AWADDR_I[4:2]], S_AXI_WDATA_I, S_AXI_WSTRB_I);
          end
          else
          begin
            wr_hit = 1'b0;
          end
        end
      endcase
      nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rd_fire)
    begin
      nxt_rresp = RESP_OKAY;
      case (S_AXI_ARADDR_I)
        ADDR_CTRL: nxt_rdata = {27'h0, light_ff, 1'b0, edge_ff, mode_ff};
        ADDR_EXPO: nxt_rdata = expo_ff;
        ADDR_FRAMES: nxt_rdata = {20'h0, frames_ff};
        ADDR_OFFSET: nxt_rdata = {16'h0, offset_ff};
        ADDR_UIO: nxt_rdata = {10'h0, uio_s2_ff, 2'h0, uoe_ff, 2'h0, uout_ff};
        ADDR_STATUS: nxt_rdata = {4'h0, stored_ff, 12'h0, send_ff, rd_busy_ff, warm_ok_ff, ACQ_BUSY_O};
        default:
        begin
          if (S_AXI_ARADDR_I[7:5] == ADDR_LIST[7:5] && S_AXI_ARADDR_I[1:0] == 2'h0)
          begin
            nxt_rdata = list_ff[S_AXI_ARADDR_I[4:2]];
          end
          else
          begin
            nxt_rdata = 32'h0000_0000;
            nxt_rresp = RESP_SLVERR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      awready_ff <= 1'b0;
      arready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
      mode_ff <= MODE_SINGLE;
      edge_ff <= 1'b0;
      light_ff <= 1'b0;
      expo_ff <= EXPO_RST;
      frames_ff <= FRAMES_RST;
      offset_ff <= OFFSET_RST;
      uout_ff <= '0;
      uoe_ff <= '0;
      for (int i = 0; i < LIST_DEPTH; i++)
      begin
        list_ff[i] <= EXPO_RST;
      end
    end
    else if (CE_I)
    begin
      awready_ff <= nxt_awready;
      arready_ff <= nxt_arready;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      mode_ff <= nxt_mode;
      edge_ff <= nxt_edge;
      light_ff <= nxt_light;
      expo_ff <= nxt_expo;
      frames_ff <= nxt_frames;
      offset_ff <= nxt_offset;
      uout_ff <= nxt_uout;
      uoe_ff <= nxt_uoe;
      list_ff <= nxt_list;
    end
  end

  // edge detector reads only synchronised stages
  assign trig_hit = edge_ff ? (trig_s3_ff && !trig_s2_ff) : (!trig_s3_ff && trig_s2_ff);
  // a stalled FIFO freezes the sensor clock so no pixel is dropped once warm_ok_ff is set
  assign stall = rd_busy_ff && !fifo_ready;
  assign rise = !stall && div_ff == DIV_LAST && !sclk_ff;
  assign push = rd_busy_ff && rise && warm_ok_ff;
  assign push_data = '{region: classify(pix_ff), value: pix_s2_ff};
  assign arm_ok = frames_ff != 12'h000 && frames_ff <= MAX_SPECTRA
    && (mode_ff != MODE_LIST || frames_ff <= 12'(LIST_DEPTH));
  assign more = taken_ff + 12'h001 < frames_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_taken = taken_ff;
    nxt_idx = idx_ff;
    nxt_xfer = 1'b0;
    nxt_send = send_ff;
    nxt_stored = stored_ff;
    nxt_pix = pix_ff;
    nxt_rd_busy = rd_busy_ff;
    nxt_div = stall ? div_ff : (div_ff == DIV_LAST ? 8'h00 : div_ff + 8'h01);
    nxt_sclk = (!stall && div_ff == DIV_LAST) ? !sclk_ff : sclk_ff;
    nxt_warm = warm_ff;
    nxt_warm_ok = warm_ok_ff;
    if (rise && !warm_ok_ff)
    begin
      nxt_warm = warm_ff + 15'h0001;
      nxt_warm_ok = warm_ff == WARM_LAST;
    end
    if (rise && rd_busy_ff)
    begin
      nxt_pix = pix_ff + 12'h001;
      if (pix_ff == PIX_LINE_LAST)
      begin
        nxt_rd_busy = 1'b0;
        nxt_stored = stored_ff + 12'h001;
      end
    end
    case (state_ff)
      ST_IDLE, ST_DONE:
      begin
        if (arm && arm_ok)
        begin
          nxt_state = ST_WAIT;
          nxt_taken = 12'h000;
          nxt_idx = 3'h0;
          nxt_stored = 12'h000;
          nxt_send = 1'b0;
        end
      end
      ST_WAIT:
      begin
        if (trig_hit)
        begin
          nxt_state = ST_EXPOSE;
          nxt_cnt = mode_ff == MODE_LIST ? list_ff[idx_ff] : expo_ff;
        end
      end
      ST_EXPOSE:
      begin
        // triggers are not looked at here, so they fall away
        if (cnt_ff > 32'h0000_0001)
        begin
          nxt_cnt = cnt_ff - 32'h0000_0001;
        end
        else if (!rd_busy_ff)
        begin
          nxt_xfer = 1'b1;
          nxt_rd_busy = 1'b1;
          nxt_pix = 12'h001;
          nxt_taken = taken_ff + 12'h001;
          if (mode_ff == MODE_FRAMES && more)
          begin
            nxt_cnt = expo_ff;
          end
          else if (mode_ff == MODE_LIST && more)
          begin
            nxt_idx = idx_ff + 3'h1;
            nxt_state = ST_WAIT;
          end
          else
          begin
            nxt_state = ST_DRAIN;
          end
        end
      end
      ST_DRAIN:
      begin
        if (!rd_busy_ff)
        begin
          nxt_state = ST_DONE;
          nxt_send = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    nxt_busy = (nxt_state != ST_IDLE) && (nxt_state != ST_DONE);
  end

  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      taken_ff <= '0;
      idx_ff <= '0;
      xfer_ff <= 1'b0;
      send_ff <= 1'b0;
      stored_ff <= '0;
      pix_ff <= '0;
      rd_busy_ff <= 1'b0;
      div_ff <= '0;
      sclk_ff <= 1'b0;
      warm_ff <= '0;
      warm_ok_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      taken_ff <= nxt_taken;
      idx_ff <= nxt_idx;
      xfer_ff <= nxt_xfer;
      send_ff <= nxt_send;
      stored_ff <= nxt_stored;
      pix_ff <= nxt_pix;
      rd_busy_ff <= nxt_rd_busy;
      div_ff <= nxt_div;
      sclk_ff <= nxt_sclk;
      warm_ff <= nxt_warm;
      warm_ok_ff <= nxt_warm_ok;
      busy_ff <= nxt_busy;
    end
  end

  tsa_fifo #(
    .WIDTH($bits(tsa_pix_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .in_data_i(push_data),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .out_data_o(SPEC_TDATA_O),
    .out_valid_o(SPEC_TVALID_O),
    .out_ready_i(SPEC_TREADY_I)
  );

  assign S_AXI_AWREADY_O = awready_ff;
  assign S_AXI_WREADY_O = awready_ff;
  assign S_AXI_BVALID_O = bvalid_ff;
  assign S_AXI_BRESP_O = bresp_ff;
  assign S_AXI_ARREADY_O = arready_ff;
  assign S_AXI_RVALID_O = rvalid_ff;
  assign S_AXI_RRESP_O = rresp_ff;
  assign S_AXI_RDATA_O = rdata_ff;
  assign USER_IO_O = uout_ff;
  assign USER_IO_OE_O = uoe_ff;
  assign LIGHT_SOURCE_O = light_ff;
  assign FE_OFFSET_O = offset_ff;
  assign SENSOR_CLK_O = sclk_ff;
  assign SENSOR_XFER_O = xfer_ff;
  assign HOST_SEND_O = send_ff;
  assign ACQ_BUSY_O = busy_ff;
endmodule // tsa_top
`default_nettype wire

/* test/tsa_top_assertions.sv */
// port-level checks for the acquisition block
`timescale 1ns/1ps
`default_nettype none
module tsa_top_assertions
  import tsa_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic SENSOR_XFER_O,
  input wire tsa_pkg::tsa_pix_t SPEC_TDATA_O,
  input wire logic SPEC_TVALID_O,
  input wire logic SPEC_TREADY_I,
  input wire logic HOST_SEND_O,
  input wire logic ACQ_BUSY_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_wr_take;
    S_AXI_AWREADY_O && S_AXI_WREADY_O;
  endsequence
  sequence s_resp_up;
    S_AXI_BVALID_O && !S_AXI_AWREADY_O;
  endsequence
  property p_wr_pair;
    S_AXI_AWREADY_O |-> S_AXI_WREADY_O && S_AXI_AWVALID_I && S_AXI_WVALID_I;
  endproperty
  property p_wr_resp;
    s_wr_take |=> s_resp_up;
  endproperty
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  property p_rd_resp;
    S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
  endproperty
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  property p_xfer_pulse;
    SENSOR_XFER_O |=> !SENSOR_XFER_O;
  endproperty
  property p_xfer_in_run;
    SENSOR_XFER_O |-> ACQ_BUSY_O && !HOST_SEND_O;
  endproperty
  property p_stream_hold;
    SPEC_TVALID_O && !SPEC_TREADY_I |=> SPEC_TVALID_O && $stable(SPEC_TDATA_O);
  endproperty
  property p_region_code;
    SPEC_TVALID_O |-> SPEC_TDATA_O.region != 2'h3;
  endproperty
  property p_send_after_run;
    HOST_SEND_O |-> !ACQ_BUSY_O;
  endproperty
  property p_busy_from_arm;
    $rose(ACQ_BUSY_O) |-> $past(S_AXI_AWREADY_O) && !HOST_SEND_O;
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write ready without both valids");
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_rd_resp: assert property (p_rd_resp) else $error("read data missing");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_xfer_pulse: assert property (p_xfer_pulse) else $error("transfer pulse too long");
  a_xfer_in_run: assert property (p_xfer_in_run) else $error("exposure outside a run");
  a_stream_hold: assert property (p_stream_hold) else $error("pixel beat changed while stalled");
  a_region_code: assert property (p_region_code) else $error("bad region code");
  a_send_after_run: assert property (p_send_after_run) else $error("store sent while busy");
  a_busy_from_arm: assert property (p_busy_from_arm) else $error("run started without arm");
  c_send: cover property ($rose(HOST_SEND_O));
endmodule // tsa_top_assertions
`default_nettype wire

/* test/tsa_partner.sv */
// trigger source and spectrum store sink facing the acquisition block
`timescale 1ns/1ps
`default_nettype none
module tsa_partner
  import tsa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic trigger_o,
  output logic tready_o,
  input wire tsa_pkg::tsa_pix_t tdata_i,
  input wire logic tvalid_i
);
  int n_dummy;
  int n_black;
  int n_active;
  int n_bad;
  int beat;
  int stall;
  initial trigger_o = 1'b0;
  // region worked out from the pixel position alone
  function automatic tsa_region_t region_of(input int idx);
    if (idx <= 12 || idx == 31 || idx == 32 || idx >= 2081) return REG_DUMMY;
    if (idx <= 30) return REG_BLACK;
    return REG_ACTIVE;
  endfunction
  task automatic idle_level(input logic lvl);
    @(posedge clk_i);
    trigger_o <= lvl;
  endtask
  // the pin is ours alone; the block only reads it
  task automatic pulse(input logic idle);
    @(posedge clk_i);
    trigger_o <= ~idle;
    repeat (6) @(posedge clk_i);
    trigger_o <= idle;
  endtask
  // a long stall early in each line fills the block's buffer until it refuses
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {n_dummy, n_black, n_active, n_bad, beat, stall} <= '0;
      tready_o <= 1'b0;
    end
    else
    begin
      tready_o <= (stall == 0);
      if (stall > 0) stall <= stall - 1;
      if (tvalid_i && tready_o)
      begin
        beat <= beat + 1;
        if (beat % 2086 == 100) stall <= 300;
        if (tdata_i.region !== region_of(beat % 2086 + 1)) n_bad <= n_bad + 1;
        if (tdata_i.region === REG_DUMMY) n_dummy <= n_dummy + 1;
        if (tdata_i.region === REG_BLACK) n_black <= n_black + 1;
        if (tdata_i.region === REG_ACTIVE) n_active <= n_active + 1;
      end
    end
  end
endmodule // tsa_partner
`default_nettype wire

/* test/test_tsa_top.sv */
// self-checking bench for the acquisition block
`timescale 1ns/1ps
`default_nettype none
module test_tsa_top;
  import tsa_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ce = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, light, sclk, xfer, tvalid, tready, host_send, busy, trig;
  logic [1:0] bresp, rresp, last_resp;
  logic [5:0] uio_o, uio_oe;
  logic [5:0] uio_i = 6'h2A;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] offset_o;
  logic [15:0] pix = 16'h0000;
  tsa_pix_t tdata;
  int mismatches = 0, checks_done = 0, cyc = 0;
  logic [31:0] rv;
  always #10 clk = ~clk;
  always @(posedge clk) pix <= pix + 16'h0001;
  tsa_top #(.SCLK_DIV(2), .WARM_PULSES(4), .FIFO_DEPTH(32)) u_dut (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .TRIGGER_I(trig), .PIX_DATA_I(pix), .USER_IO_I(uio_i), .USER_IO_O(uio_o),
    .USER_IO_OE_O(uio_oe), .LIGHT_SOURCE_O(light), .FE_OFFSET_O(offset_o), .SENSOR_CLK_O(sclk),
    .SENSOR_XFER_O(xfer), .SPEC_TDATA_O(tdata), .SPEC_TVALID_O(tvalid), .SPEC_TREADY_I(tready),
    .HOST_SEND_O(host_send), .ACQ_BUSY_O(busy));
  tsa_partner u_partner (.clk_i(clk), .rst_i(rst), .trigger_o(trig), .tready_o(tready), .tdata_i(tdata),
    .tvalid_i(tvalid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    last_resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rv = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_send;
    while (host_send !== 1'b1) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask
  task automatic t_reset_values;
    check(offset_o, 32'h0000_03E8);
    rd(ADDR_OFFSET);
    check(rv, 32'h0000_03E8);
    rd(ADDR_EXPO);
    check(rv, 32'h0000_C350);
    rd(ADDR_FRAMES);
    check(rv, 32'h0000_0001);
    rd(8'h18);
    check(rv, 32'h0000_0000);
    check(last_resp, RESP_SLVERR);
    wr(8'h1C, 32'hFFFF_FFFF);
    check(last_resp, RESP_SLVERR);
    rd(ADDR_STATUS);
    check(rv[1], 1'b1);
  endtask
  task automatic t_user_lines;
    logic s;
    wr(ADDR_UIO, 32'h0000_3F15);
    check({uio_oe, uio_o}, 12'hFD5);
    uio_i <= 6'h15;
    rd(ADDR_UIO);
    check(rv, 32'h0015_3F15);
    wr(ADDR_CTRL, 32'h0000_0010);
    check(light, 1'b1);
    wr(ADDR_OFFSET, 32'h0000_0500);
    check(offset_o, 16'h0500);
    wstrb <= 4'h1;
    wr(ADDR_OFFSET, 32'h0000_0A77);
    check(offset_o, 16'h0577);
    wstrb <= 4'hF;
    ce <= 1'b0;
    @(posedge clk);
    s = sclk;
    repeat (10) @(posedge clk);
    check(sclk, s);
    ce <= 1'b1;
  endtask
  task automatic t_single;
    int d0, b0, a0;
    d0 = u_partner.n_dummy;
    b0 = u_partner.n_black;
    a0 = u_partner.n_active;
    wr(ADDR_EXPO, 32'd20);
    wr(ADDR_CTRL, 32'h0000_0008);
    check(busy, 1'b1);
    u_partner.pulse(1'b0);
    repeat (60) @(posedge clk);
    u_partner.pulse(1'b0);
    wait_send();
    check(u_partner.n_dummy - d0, 20);
    check(u_partner.n_black - b0, 18);
    check(u_partner.n_active - a0, 2048);
    check(u_partner.n_bad, 0);
    rd(ADDR_STATUS);
    check(rv[27:16], 12'h001);
  endtask
  task automatic t_frames;
    int n, b0;
    n = 0;
    b0 = u_partner.beat;
    wr(ADDR_FRAMES, 32'd2);
    u_partner.idle_level(1'b1);
    wr(ADDR_CTRL, 32'h0000_000D);
    check(host_send, 1'b0);
    u_partner.pulse(1'b1);
    while (host_send !== 1'b1)
    begin
      @(posedge clk);
      if (xfer === 1'b1) n++;
    end
    check(n, 2);
    repeat (20) @(posedge clk);
    check(u_partner.beat - b0, 4172);
  endtask
  task automatic t_list;
    int t0, e0, e1, b0;
    wr(ADDR_LIST, 32'd20);
    wr(ADDR_LIST + 8'h04, 32'd40);
    u_partner.idle_level(1'b0);
    wr(ADDR_CTRL, 32'h0000_000A);
    b0 = u_partner.beat;
    t0 = cyc;
    u_partner.pulse(1'b0);
    do @(posedge clk); while (xfer !== 1'b1);
    e0 = cyc - t0;
    while (u_partner.beat - b0 < 2086) @(posedge clk);
    repeat (20) @(posedge clk);
    check({host_send, busy}, 2'b01);
    t0 = cyc;
    u_partner.pulse(1'b0);
    do @(posedge clk); while (xfer !== 1'b1);
    e1 = cyc - t0;
    check(e1 - e0, 20);
    wait_send();
    check(u_partner.beat - b0, 4172);
  endtask
  task automatic t_refused_arm;
    wr(ADDR_FRAMES, 32'h0000_0FA1);
    wr(ADDR_CTRL, 32'h0000_0009);
    repeat (3) @(posedge clk);
    check({host_send, busy}, 2'b10);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    t_reset_values();
    t_user_lines();
    t_single();
    t_frames();
    t_list();
    t_refused_arm();
    report_and_stop();
  end
endmodule // test_tsa_top
bind tsa_top tsa_top_assertions u_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .SENSOR_XFER_O(SENSOR_XFER_O), .SPEC_TDATA_O(SPEC_TDATA_O),
  .SPEC_TVALID_O(SPEC_TVALID_O), .SPEC_TREADY_I(SPEC_TREADY_I), .HOST_SEND_O(HOST_SEND_O), .ACQ_BUSY_O(ACQ_BUSY_O));
`default_nettype wire
